/* File: design/flash_gate_regs.vh */
// Register offsets, field positions, reset values and timing counts
// for the flash access gate. Assumes a 100 MHz ref_clk.
`ifndef FLASH_GATE_REGS_VH
`define FLASH_GATE_REGS_VH

// APB byte addresses, 20-bit address space
`define ADDR_W 20
`define OFS_DS_CTRL 20'hf0090
`define OFS_SECURITY 20'hf0094
`define OFS_STATUS 20'hf0098

// Control register fields
`define DS_CTRL_RESET 8'h00
`define DS_CTRL_EN_BIT 0

// Security register fields
`define SEC_ERASE_BIT 0
`define SEC_WRITE_BIT 1
`define SEC_BOOT0_BIT 2
`define SEC_RELEASE_BIT 3

// Status register fields
`define ST_SETUP_DONE_BIT 0
`define ST_DISCARD_BIT 1
`define ST_SWITCH_WAIT_BIT 2
`define ST_DATA_BUSY_BIT 3
`define ST_CODE_BUSY_BIT 4
`define ST_DMA_READY_BIT 5

// Boot cluster 0 spans 00000h..00fffh
`define BOOT0_LIMIT 20'h01000
// Erase block is 1 KB: block index starts at address bit 10
`define BLOCK_LSB 10

// Timing: clock rate and times as printed
`define CLK_MHZ 100
`define SETUP_HS_NS 5000
`define SETUP_LS_NS 720
`define SWITCH_HS_NS 5000
`define SWITCH_LS_NS 1000
`define DMA_HOLD_CYC 3
// Least times, rounded up to whole cycles
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define SETUP_HS_CYC `NS_TO_CYC(`SETUP_HS_NS)
`define SETUP_LS_CYC `NS_TO_CYC(`SETUP_LS_NS)
`define SWITCH_HS_CYC `NS_TO_CYC(`SWITCH_HS_NS)
`define SWITCH_LS_CYC `NS_TO_CYC(`SWITCH_LS_NS)

`endif

/* File: design/level_sync3.v */
// Three-stage synchroniser for a level from another clock domain.
// Assumes the level is stable for at least three ref_clk cycles.
`default_nettype none

module level_sync3 (
	input wire ref_clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire async_in, // Level from outside the domain
	output reg sync_q // Filtered level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge ref_clk) begin
		if (srst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Accept a change once two stages agree
			if (s2_q == s3_q)
				sync_q <= s3_q;
		end
	end
endmodule // level_sync3

`default_nettype wire

/* File: design/wait_timer.v */
// Down-counting wait timer: start loads a count, done rises when it ends.
// Assumes start is a one-cycle pulse on ref_clk; abort may be held high as a level.
`default_nettype none

module wait_timer #(
	parameter W = 10
) (
	input wire ref_clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire start, // Load count and begin waiting
	input wire abort, // Stop waiting, done stays low
	input wire [W-1:0] load, // Cycles to wait
	output reg busy_q, // Wait in progress
	output reg done_q // Wait elapsed
);
	reg [W-1:0] cnt_q;

	always @(posedge ref_clk) begin
		if (srst || abort) begin
			cnt_q <= {W{1'b0}};
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (start) begin
			cnt_q <= load;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else if (busy_q) begin
			if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // wait_timer

`default_nettype wire

/* File: design/flash_access_gate.v */
// Flash access gate: security checks on erase/write commands and CPU
// access control for the data store area, with an APB register slave.
// Assumes flash busy levels come from the flash macro's own clock;
// all other request inputs are ref_clk logic.
// What this block does
// - Serial mode, erase prohibited: reject erase, still accept writes.
// - Serial mode, write prohibited: accept erase, reject code writes.
// - Boot cluster 0 prohibited: reject its erase and write, any mode.
// - Self-programming ignores erase/write prohibits; shield window limits.
// - Erase and boot-0 prohibits, once set, never clear.
// - Write prohibit clears only on release in serial mode.
// - Release only if no other prohibit and both areas blank.
// - Data store erase works on whole 1 KB blocks.
// - Data store accepts byte accesses only; CPU reads it directly.
// - Code fetch continues while the data store is rewritten.
// - No instruction fetch from the data store.
// - No data store access while code flash is rewritten.
// - Control register is frozen during a data store rewrite.
// - No stop mode during a data store rewrite.
// - Control resets to 00h; bit 0 enables data store access.
// - Access blocked for 5 us (HS) or 720 ns (LS) after enable.
// - After sub-to-main switch, first read undefined, then wait.
//
// The APB interface to the registers was chosen for this implementation.
`include "flash_gate_regs.vh"
`default_nettype none

module flash_access_gate #(
	parameter TW = 10
) (
	input wire ref_clk, // 100 MHz system clock
	input wire srst, // Synchronous reset, active high
	input wire [`ADDR_W-1:0] paddr, // APB address
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire serial_mode, // 1 serial programming, 0 self-programming
	input wire cmd_valid, // Erase/write command strobe
	input wire cmd_erase, // 1 block erase, 0 write
	input wire cmd_data_area, // Target is the data store area
	input wire cmd_in_window, // Target lies inside shield window
	input wire [`ADDR_W-1:0] cmd_addr, // Command target address
	output reg cmd_accept_q, // Command accepted, pulse
	output reg cmd_reject_q, // Command rejected, pulse
	output reg [`ADDR_W-`BLOCK_LSB-1:0] cmd_block_q, // Erase block index
	input wire sec_set_valid, // Security set strobe
	input wire [2:0] sec_set_bits, // Erase, write, boot-0 prohibits
	input wire sec_release_valid, // Security release strobe
	input wire blank_code, // Code area fully blank
	input wire blank_data, // Data area fully blank
	input wire code_rewrite_busy, // Code rewrite, flash clock domain
	input wire background_rewrite, // Data rewrite, flash clock domain
	input wire high_speed_main_mode, // 1 HS, 0 LS main clock mode
	input wire cpu_clk_sub_select, // CPU runs on subsystem clock
	input wire df_req, // Data store access request
	input wire df_fetch, // Request is an instruction fetch
	input wire df_byte, // Access is byte wide
	input wire dma_active, // Any DMA channel in use
	input wire dma_channel_hold, // All active channels held
	input wire prev_nop, // Previous instruction was a no-op
	output reg df_grant_q, // Access granted, pulse
	output reg df_deny_q, // Access refused, pulse
	output reg df_undef_q, // Granted read carries undefined data
	input wire code_fetch_req, // Instruction fetch from code area
	output reg code_fetch_grant_q, // Code fetch served, pulse
	input wire stop_req, // Stop mode request
	output reg stop_ack_q, // Stop allowed, pulse
	output reg stop_deny_q // Stop refused, pulse
);
	localparam integer SETUP_HS_N = `SETUP_HS_CYC;
	localparam integer SETUP_LS_N = `SETUP_LS_CYC;
	localparam integer SWITCH_HS_N = `SWITCH_HS_CYC;
	localparam integer SWITCH_LS_N = `SWITCH_LS_CYC;
	localparam integer HOLD_N = `DMA_HOLD_CYC;
	localparam [TW-1:0] SETUP_HS = SETUP_HS_N[TW-1:0];
	localparam [TW-1:0] SETUP_LS = SETUP_LS_N[TW-1:0];
	localparam [TW-1:0] SWITCH_HS = SWITCH_HS_N[TW-1:0];
	localparam [TW-1:0] SWITCH_LS = SWITCH_LS_N[TW-1:0];
	localparam [1:0] HOLD_CYC = HOLD_N[1:0];
	// Clock switch tracking
	localparam [1:0] CK_IDLE = 2'd0;
	localparam [1:0] CK_DISCARD = 2'd1;
	localparam [1:0] CK_WAIT = 2'd2;

	reg en_q;
	reg en_d;
	reg erase_p_q;
	reg write_p_q;
	reg boot0_p_q;
	reg sub_q;
	reg [1:0] ck_q;
	reg [1:0] ck_d;
	reg [1:0] hold_cnt_q;
	wire code_busy;
	wire data_busy;
	wire setup_busy;
	wire setup_done;
	wire sw_busy;
	wire sw_done;
	wire sw_start;
	wire en_rise;
	wire wr_acc;
	wire [7:0] sec_wr;
	wire wr_sec;
	wire [2:0] set_bits;
	wire rel_ok;
	reg [31:0] rd_d;
	reg map_ok;
	reg cmd_ok;
	reg df_ok;
	reg dma_ok;

	level_sync3 u_sync_code (
		.ref_clk(ref_clk),
		.srst(srst),
		.async_in(code_rewrite_busy),
		.sync_q(code_busy)
	);

	level_sync3 u_sync_data (
		.ref_clk(ref_clk),
		.srst(srst),
		.async_in(background_rewrite),
		.sync_q(data_busy)
	);

	wait_timer #(.W(TW)) u_setup (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(en_rise),
		.abort(~en_d),
		.load(high_speed_main_mode ? SETUP_HS : SETUP_LS),
		.busy_q(setup_busy),
		.done_q(setup_done)
	);

	wait_timer #(.W(TW)) u_switch (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(sw_start),
		.abort(1'b0),
		.load(high_speed_main_mode ? SWITCH_HS : SWITCH_LS),
		.busy_q(sw_busy),
		.done_q(sw_done)
	);

	assign wr_acc = psel & penable & pwrite & pready;
	assign en_rise = en_d & ~en_q;
	assign sec_wr = pwdata[7:0];
	// Only a real granted read consumes the discard
	assign sw_start = (ck_q == CK_DISCARD) & df_req & df_ok;
	assign wr_sec = wr_acc & (paddr == `OFS_SECURITY);
	assign set_bits = (sec_set_valid ? sec_set_bits : 3'b000) |
		(wr_sec ? sec_wr[2:0] : 3'b000);
	assign rel_ok = serial_mode & ~erase_p_q & ~boot0_p_q & blank_code &
		blank_data &
		(sec_release_valid | (wr_sec & sec_wr[`SEC_RELEASE_BIT]));

	// Register write path
	always @* begin
		en_d = en_q;
		if (wr_acc && paddr == `OFS_DS_CTRL && !data_busy)
			en_d = pwdata[`DS_CTRL_EN_BIT];
	end

	// Read mux and decode
	always @* begin
		rd_d = 32'h0000_0000;
		map_ok = 1'b1;
		case (paddr)
		`OFS_DS_CTRL: begin
			rd_d[`DS_CTRL_EN_BIT] = en_q;
		end
		`OFS_SECURITY: begin
			rd_d[`SEC_ERASE_BIT] = erase_p_q;
			rd_d[`SEC_WRITE_BIT] = write_p_q;
			rd_d[`SEC_BOOT0_BIT] = boot0_p_q;
		end
		`OFS_STATUS: begin
			rd_d[`ST_SETUP_DONE_BIT] = setup_done;
			rd_d[`ST_DISCARD_BIT] = (ck_q == CK_DISCARD);
			rd_d[`ST_SWITCH_WAIT_BIT] = sw_busy;
			rd_d[`ST_DATA_BUSY_BIT] = data_busy;
			rd_d[`ST_CODE_BUSY_BIT] = code_busy;
			rd_d[`ST_DMA_READY_BIT] = dma_ok;
		end
		default: begin
			map_ok = 1'b0;
		end
		endcase
	end

	// Command security decision
	always @* begin
		cmd_ok = 1'b1;
		if (!cmd_data_area && cmd_addr < `BOOT0_LIMIT && boot0_p_q)
			cmd_ok = 1'b0;
		if (serial_mode) begin
			if (cmd_erase && erase_p_q)
				cmd_ok = 1'b0;
			if (!cmd_erase && write_p_q && !cmd_data_area)
				cmd_ok = 1'b0;
		end else begin
			if (!cmd_data_area && !cmd_in_window)
				cmd_ok = 1'b0;
		end
	end

	// Data store access decision
	always @* begin
		dma_ok = !dma_active || hold_cnt_q >= HOLD_CYC || prev_nop;
		df_ok = en_q & setup_done & dma_ok;
		if (!df_byte)
			df_ok = 1'b0;
		if (df_fetch)
			df_ok = 1'b0;
		if (code_busy)
			df_ok = 1'b0;
		if (ck_q == CK_WAIT)
			df_ok = 1'b0;
	end

	// Clock switch sequence
	always @* begin
		case (ck_q)
		CK_IDLE: begin
			ck_d = (sub_q && !cpu_clk_sub_select) ? CK_DISCARD : CK_IDLE;
		end
		CK_DISCARD: begin
			ck_d = sw_start ? CK_WAIT : CK_DISCARD;
		end
		CK_WAIT: begin
			ck_d = sw_done ? CK_IDLE : CK_WAIT;
		end
		default: begin
			ck_d = CK_IDLE;
		end
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			en_q <= 1'b0;
			erase_p_q <= 1'b0;
			write_p_q <= 1'b0;
			boot0_p_q <= 1'b0;
			sub_q <= 1'b0;
			ck_q <= CK_IDLE;
			hold_cnt_q <= 2'd0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			cmd_accept_q <= 1'b0;
			cmd_reject_q <= 1'b0;
			cmd_block_q <= {(`ADDR_W-`BLOCK_LSB){1'b0}};
			df_grant_q <= 1'b0;
			df_deny_q <= 1'b0;
			df_undef_q <= 1'b0;
			code_fetch_grant_q <= 1'b0;
			stop_ack_q <= 1'b0;
			stop_deny_q <= 1'b0;
		end else begin
			en_q <= en_d;
			sub_q <= cpu_clk_sub_select;
			ck_q <= ck_d;
			// Answer in the first access cycle
			pready <= psel & ~penable;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= ~map_ok;
			end
			if (!dma_active || !dma_channel_hold)
				hold_cnt_q <= 2'd0;
			else if (hold_cnt_q < HOLD_CYC)
				hold_cnt_q <= hold_cnt_q + 2'd1;
			erase_p_q <= erase_p_q | set_bits[`SEC_ERASE_BIT];
			write_p_q <= (write_p_q & ~rel_ok) | set_bits[`SEC_WRITE_BIT];
			boot0_p_q <= boot0_p_q | set_bits[`SEC_BOOT0_BIT];
			cmd_accept_q <= cmd_valid & cmd_ok;
			cmd_reject_q <= cmd_valid & ~cmd_ok;
			if (cmd_valid)
				cmd_block_q <= cmd_addr[`ADDR_W-1:`BLOCK_LSB];
			df_grant_q <= df_req & df_ok;
			df_deny_q <= df_req & ~df_ok;
			df_undef_q <= df_req & sw_start;
			code_fetch_grant_q <= code_fetch_req & ~code_busy;
			stop_ack_q <= stop_req & ~data_busy & ~setup_busy;
			stop_deny_q <= stop_req & (data_busy | setup_busy);
		end
	end
endmodule // flash_access_gate

`default_nettype wire

/* File: tb/flash_gate_properties.sv */
// Concurrent checks on the flash access gate ports.
// Assumes it is bound into flash_access_gate and keeps its port names.
`include "flash_gate_regs.vh"
`default_nettype none
module flash_gate_properties (
	input wire logic ref_clk, // Clock
	input wire logic srst, // Reset
	input wire logic cmd_valid, // Command strobe
	input wire logic cmd_data_area, // Data area target
	input wire logic cmd_in_window, // Inside window
	input wire logic serial_mode, // Serial mode
	input wire logic [`ADDR_W-1:0] cmd_addr, // Target
	input wire logic cmd_accept_q, // Accept
	input wire logic cmd_reject_q, // Reject
	input wire logic [`ADDR_W-`BLOCK_LSB-1:0] cmd_block_q, // Block
	input wire logic df_req, // Access request
	input wire logic df_fetch, // Fetch
	input wire logic df_byte, // Byte wide
	input wire logic df_grant_q, // Grant
	input wire logic df_deny_q, // Deny
	input wire logic df_undef_q, // Undefined data
	input wire logic code_rewrite_busy, // Code busy
	input wire logic background_rewrite, // Data busy
	input wire logic code_fetch_req, // Code fetch
	input wire logic code_fetch_grant_q, // Fetch served
	input wire logic stop_req, // Stop request
	input wire logic stop_ack_q, // Stop allowed
	input wire logic stop_deny_q // Stop refused
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [`ADDR_W-`BLOCK_LSB-1:0] cmd_blk = cmd_addr[`ADDR_W-1:`BLOCK_LSB];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_fetch; df_req && df_fetch |=> df_deny_q && !df_grant_q; endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch from data store granted");
	property p_byte; df_req && !df_byte |=> df_deny_q; endproperty
	a_byte: assert property (p_byte)
		else $error("wide access granted");
	property p_code; code_rewrite_busy [*5] ##0 df_req |=> df_deny_q; endproperty
	a_code: assert property (p_code)
		else $error("access during code rewrite");
	property p_stop;
		background_rewrite [*5] ##0 stop_req |=> stop_deny_q && !stop_ack_q;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop during data rewrite");
	property p_block;
		cmd_valid |=> cmd_block_q == $past(cmd_blk);
	endproperty
	a_block: assert property (p_block)
		else $error("erase block index wrong");
	property p_one; cmd_valid |=> cmd_accept_q != cmd_reject_q; endproperty
	a_one: assert property (p_one)
		else $error("command answer not single");
	property p_win;
		cmd_valid && !serial_mode && !cmd_data_area && !cmd_in_window
			|=> cmd_reject_q;
	endproperty
	a_win: assert property (p_win)
		else $error("write outside window accepted");
	property p_cf;
		!code_rewrite_busy [*5] ##0 code_fetch_req |=> code_fetch_grant_q;
	endproperty
	a_cf: assert property (p_cf)
		else $error("code fetch not served");
	property p_undef; df_undef_q |-> df_grant_q && $past(df_req); endproperty
	a_undef: assert property (p_undef)
		else $error("undefined flag without read");
	c_rej: cover property (cmd_valid ##1 cmd_reject_q);
	c_undef: cover property (df_undef_q);
	c_sdeny: cover property (stop_req ##1 stop_deny_q);
endmodule // flash_gate_properties
bind flash_access_gate flash_gate_properties u_flash_gate_properties (.*);
`default_nettype wire

/* File: tb/flash_busy_model.sv */
// Flash macro stand-in: holds a busy level for N cycles per start pulse.
// Assumes start pulses come from the bench on ref_clk.
`default_nettype none
module flash_busy_model #(
	parameter int N = 40
) (
	input wire logic ref_clk, // Clock
	input wire logic go_data, // Start data store rewrite
	input wire logic go_code, // Start code rewrite
	output logic background_rewrite, // Data rewrite busy
	output logic code_rewrite_busy // Code rewrite busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int dn = 0;
	int cn = 0;
	always @(posedge ref_clk) begin
		dn <= go_data ? N : (dn > 0 ? dn - 1 : 0);
		cn <= go_code ? N : (cn > 0 ? cn - 1 : 0);
	end
	assign background_rewrite = dn > 0;
	assign code_rewrite_busy = cn > 0;
endmodule // flash_busy_model
`default_nettype wire

/* File: tb/tb_flash_access_gate.sv */
// Bench for the flash access gate: APB, command, access and stop stimulus.
// Assumes flash_busy_model drives the flash busy levels.
`include "flash_gate_regs.vh"
`default_nettype none
module tb_flash_access_gate;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [`ADDR_W-1:0] paddr = 0, cmd_addr = 0;
	logic [31:0] pwdata = 0, d;
	logic serial_mode = 1, cmd_valid = 0, cmd_erase = 0, cmd_data_area = 0;
	logic cmd_in_window = 1, sec_set_valid = 0, sec_release_valid = 0;
	logic [2:0] sec_set_bits = 0;
	logic blank_code = 1, blank_data = 1, high_speed_main_mode = 0;
	logic cpu_clk_sub_select = 0, df_req = 0, df_fetch = 0, df_byte = 1;
	logic dma_active = 0, dma_channel_hold = 0, prev_nop = 0;
	logic code_fetch_req = 0, stop_req = 0, go_data = 0, go_code = 0;
	wire [31:0] prdata;
	wire [`ADDR_W-`BLOCK_LSB-1:0] cmd_block_q;
	wire pready, pslverr, cmd_accept_q, cmd_reject_q, df_grant_q, df_deny_q;
	wire df_undef_q, code_fetch_grant_q, stop_ack_q, stop_deny_q;
	wire background_rewrite, code_rewrite_busy;
	int fail_count = 0, check_count = 0, cyc = 0;
	flash_access_gate u_flash_access_gate (.*);
	flash_busy_model u_flash_busy_model (.ref_clk(ref_clk),
		.go_data(go_data), .go_code(go_code),
		.background_rewrite(background_rewrite),
		.code_rewrite_busy(code_rewrite_busy));
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic ck(input logic ok);
		check_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: check %0d", $time, check_count);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic apb(input logic w, input logic [`ADDR_W-1:0] a,
		input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic df(input logic f, input logic b, input logic [2:0] x);
		@(posedge ref_clk);
		df_req <= 1;
		df_fetch <= f;
		df_byte <= b;
		@(posedge ref_clk);
		df_req <= 0;
		@(posedge ref_clk);
		ck({df_grant_q, df_deny_q, df_undef_q} === x);
	endtask
	task automatic cm(input logic er, input logic [`ADDR_W-1:0] a,
		input logic da, input logic [1:0] x);
		@(posedge ref_clk);
		cmd_valid <= 1;
		cmd_erase <= er;
		cmd_addr <= a;
		cmd_data_area <= da;
		@(posedge ref_clk);
		cmd_valid <= 0;
		@(posedge ref_clk);
		ck({cmd_accept_q, cmd_reject_q} === x);
		ck(cmd_block_q === a[`ADDR_W-1:`BLOCK_LSB]);
	endtask
	task automatic sec(input logic [2:0] b, input logic rel);
		@(posedge ref_clk);
		sec_set_valid <= |b;
		sec_set_bits <= b;
		sec_release_valid <= rel;
		@(posedge ref_clk);
		sec_set_valid <= 0;
		sec_release_valid <= 0;
	endtask
	task automatic sc(input logic [2:0] x);
		@(posedge ref_clk);
		stop_req <= 1;
		code_fetch_req <= 1;
		@(posedge ref_clk);
		stop_req <= 0;
		code_fetch_req <= 0;
		@(posedge ref_clk);
		ck({stop_ack_q, stop_deny_q, code_fetch_grant_q} === x);
	endtask
	task automatic t_regs();
		apb(0, `OFS_DS_CTRL, 0);
		ck(d === 32'h0);
		apb(1, `OFS_DS_CTRL, 32'hff);
		apb(0, `OFS_DS_CTRL, 0);
		ck(d === 32'h1);
		apb(0, 20'hf00a0, 0);
		ck(e === 1'b1);
	endtask
	task automatic t_setup();
		apb(1, `OFS_DS_CTRL, 0);
		apb(1, `OFS_DS_CTRL, 1);
		sc(3'b011);
		apb(1, `OFS_DS_CTRL, 0);
		sc(3'b101);
		apb(1, `OFS_DS_CTRL, 1);
		tick(64);
		df(0, 1, 3'b010);
		tick(6);
		df(0, 1, 3'b100);
		high_speed_main_mode <= 1;
		apb(1, `OFS_DS_CTRL, 0);
		apb(1, `OFS_DS_CTRL, 1);
		tick(480);
		df(0, 1, 3'b010);
		tick(20);
		df(0, 1, 3'b100);
		high_speed_main_mode <= 0;
	endtask
	task automatic t_dma();
		dma_active <= 1;
		df(0, 1, 3'b010);
		prev_nop <= 1;
		df(0, 1, 3'b100);
		prev_nop <= 0;
		dma_channel_hold <= 1;
		tick(4);
		df(0, 1, 3'b100);
		dma_channel_hold <= 0;
		dma_active <= 0;
		df(1, 1, 3'b010);
		df(0, 0, 3'b010);
	endtask
	task automatic t_switch();
		cpu_clk_sub_select <= 1;
		tick(2);
		cpu_clk_sub_select <= 0;
		tick(2);
		df(0, 1, 3'b101);
		df(0, 1, 3'b010);
		tick(100);
		df(0, 1, 3'b100);
	endtask
	task automatic t_bgo();
		go_data <= 1;
		tick(1);
		go_data <= 0;
		tick(5);
		apb(1, `OFS_DS_CTRL, 0);
		apb(0, `OFS_DS_CTRL, 0);
		ck(d === 32'h1);
		sc(3'b011);
		tick(40);
		go_code <= 1;
		tick(1);
		go_code <= 0;
		tick(5);
		df(0, 1, 3'b010);
		tick(45);
	endtask
	task automatic t_sec();
		sec(3'b010, 0);
		cm(0, 20'h02000, 0, 2'b01);
		cm(1, 20'h02000, 0, 2'b10);
		cm(0, 20'h02000, 1, 2'b10);
		serial_mode <= 0;
		cm(0, 20'h02000, 0, 2'b10);
		cmd_in_window <= 0;
		cm(0, 20'h02000, 0, 2'b01);
		cmd_in_window <= 1;
		sec(3'b000, 1);
		apb(0, `OFS_SECURITY, 0);
		ck(d[2:0] === 3'b010);
		serial_mode <= 1;
		blank_data <= 0;
		sec(3'b000, 1);
		apb(0, `OFS_SECURITY, 0);
		ck(d[2:0] === 3'b010);
		blank_data <= 1;
		apb(1, `OFS_SECURITY, 32'h8);
		apb(0, `OFS_SECURITY, 0);
		ck(d[2:0] === 3'b000);
		sec(3'b101, 0);
		cm(1, 20'h02000, 0, 2'b01);
		cm(0, 20'h02000, 0, 2'b10);
		cm(0, 20'h00fff, 0, 2'b01);
		serial_mode <= 0;
		cm(1, 20'h00000, 0, 2'b01);
		cm(1, 20'h02000, 0, 2'b10);
		serial_mode <= 1;
		sec(3'b010, 0);
		apb(1, `OFS_SECURITY, 32'h8);
		apb(0, `OFS_SECURITY, 0);
		ck(d[2:0] === 3'b111);
	endtask
	task summarize();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		tick(10);
		srst <= 0;
		t_regs();
		t_setup();
		t_dma();
		t_switch();
		t_bgo();
		t_sec();
		summarize();
	end
endmodule // tb_flash_access_gate
`default_nettype wire
